/* File: zsd_top.sv */
// zero speed detector with register port and output pin
`timescale 1ns/10ps
module zsd_top #(
    parameter int SPEED_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // measured speed, signed rpm
    input wire logic signed [SPEED_W-1:0] motor_speed,
    // outputs
    output logic zero_speed_flag,
    output logic zsp_pin
);
    // ------------------------------------------------------------
    // parameter checks at simulation start
    // ------------------------------------------------------------
    // below 12 bits the speed cannot reach the top switching point,
    // so a flag set at a high level could never clear again; above 17
    // bits the magnitude no longer fits the 17 bit compare path
    initial begin
        if (SPEED_W < 12 || SPEED_W > 17) begin
            $error("SPEED_W must lie between 12 and 17");
        end
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_n = rst_s2_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] zero_speed_level_q;
    logic [15:0] zero_speed_level_d;
    logic [7:0] output_pin_function_select_q;
    logic [7:0] output_pin_function_select_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [15:0] wr_level;
    logic hit_level;
    logic hit_pinsel;
    logic hit_status;
    logic hit_speed;

    // detector values, declared here as the read path shows them
    logic signed [17:0] speed_ext;
    logic [16:0] speed_mag;
    logic [16:0] lo_point;
    logic [16:0] hi_point;
    logic below_lo;
    logic above_hi;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_level = (reg_addr == zsd_pkg::ZSD_LEVEL_OFS);
    assign hit_pinsel = (reg_addr == zsd_pkg::ZSD_PINSEL_OFS);
    assign hit_status = (reg_addr == zsd_pkg::ZSD_STATUS_OFS);
    assign hit_speed = (reg_addr == zsd_pkg::ZSD_SPEED_OFS);

    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    // unmapped writes are ignored, unmapped reads give zero;
    // read data stand for the single cycle after the strobe
    always_comb begin
        wr_level = reg_wdata[15:0];
        zero_speed_level_d = zero_speed_level_q;
        output_pin_function_select_d = output_pin_function_select_q;
        if (reg_wr && hit_level) begin
            // out of range writes clamp to limits
            if (wr_level < zsd_pkg::ZSD_LEVEL_MIN) begin
                zero_speed_level_d = zsd_pkg::ZSD_LEVEL_MIN;
            end else if (wr_level > zsd_pkg::ZSD_LEVEL_MAX) begin
                zero_speed_level_d = zsd_pkg::ZSD_LEVEL_MAX;
            end else begin
                zero_speed_level_d = wr_level;
            end
        end
        if (reg_wr && hit_pinsel) begin
            output_pin_function_select_d = reg_wdata[7:0];
        end
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                zsd_pkg::ZSD_LEVEL_OFS: rdata_d = {16'h0000, zero_speed_level_q};
                zsd_pkg::ZSD_PINSEL_OFS: rdata_d = {24'h00_0000, output_pin_function_select_q};
                zsd_pkg::ZSD_STATUS_OFS: rdata_d = {31'h0000_0000, zero_speed_flag};
                zsd_pkg::ZSD_SPEED_OFS: rdata_d = {15'h0000, speed_mag};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_speed_level_q <= zsd_pkg::ZSD_LEVEL_RST;
            output_pin_function_select_q <= zsd_pkg::ZSD_PINSEL_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            zero_speed_level_q <= zero_speed_level_d;
            output_pin_function_select_q <= output_pin_function_select_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // detector
    // ------------------------------------------------------------
    logic flag_q;
    logic flag_d;
    logic pin_q;
    logic pin_d;

    always_comb begin
        // magnitude, same threshold both directions
        // sign extend one bit further so the most negative speed negates safely
        speed_ext = 18'(motor_speed);
        if (motor_speed[SPEED_W-1]) begin
            speed_mag = 17'(-speed_ext);
        end else begin
            speed_mag = 17'(speed_ext);
        end
        // the level never goes below ten, so the low point cannot wrap
        lo_point = {1'b0, zero_speed_level_q} - {1'b0, zsd_pkg::ZSD_HYST};
        hi_point = {1'b0, zero_speed_level_q} + {1'b0, zsd_pkg::ZSD_HYST};
        below_lo = (speed_mag < lo_point);
        above_hi = (speed_mag > hi_point);
        flag_d = flag_q;
        if (below_lo) begin
            flag_d = 1'b1;
        end else if (above_hi) begin
            flag_d = 1'b0;
        end
        // select taken from its next value so pin and select move together
        pin_d = flag_d && (output_pin_function_select_d == zsd_pkg::ZSD_FUNC_ZSP);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            pin_q <= pin_d;
        end
    end
    assign zero_speed_flag = flag_q;
    assign zsp_pin = pin_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_flag_sets_low: assert property (@(posedge clk) disable iff (!rst_n)
        speed_mag < lo_point |=> zero_speed_flag)
        else $error("flag not set below low point");
    a_flag_clears_high: assert property (@(posedge clk) disable iff (!rst_n)
        speed_mag > hi_point |=> !zero_speed_flag)
        else $error("flag not cleared above high point");
    a_flag_holds_band: assert property (@(posedge clk) disable iff (!rst_n)
        (speed_mag >= lo_point && speed_mag <= hi_point) |=> $stable(zero_speed_flag))
        else $error("flag changed inside band");
    a_level_in_range: assert property (@(posedge clk) disable iff (!rst_n)
        zero_speed_level_q >= zsd_pkg::ZSD_LEVEL_MIN
        && zero_speed_level_q <= zsd_pkg::ZSD_LEVEL_MAX)
        else $error("level out of range");
    a_sign_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        motor_speed[SPEED_W-1] && below_lo |=> zero_speed_flag)
        else $error("negative low speed not flagged");
    a_pin_follows: assert property (@(posedge clk) disable iff (!rst_n)
        zsp_pin == (zero_speed_flag
        && output_pin_function_select_q == zsd_pkg::ZSD_FUNC_ZSP))
        else $error("pin does not follow selected flag");
    a_pin_unsel: assert property (@(posedge clk) disable iff (!rst_n)
        output_pin_function_select_q != zsd_pkg::ZSD_FUNC_ZSP |-> !zsp_pin)
        else $error("pin on while not selected");
    a_read_level: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_level |=> reg_rdata == {16'h0000, $past(zero_speed_level_q)})
        else $error("level readback wrong");

    // ------------------------------------------------------------
    // further register checks
    // ------------------------------------------------------------
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data present without a read");
    a_read_status: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_status |=> reg_rdata == {31'h0000_0000, $past(zero_speed_flag)})
        else $error("status readback wrong");
    a_read_pinsel: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && hit_pinsel
        |=> reg_rdata == {24'h00_0000, $past(output_pin_function_select_q)})
        else $error("pin select readback wrong");
    a_clamp_low: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && hit_level && wr_level < zsd_pkg::ZSD_LEVEL_MIN
        |=> zero_speed_level_q == zsd_pkg::ZSD_LEVEL_MIN)
        else $error("low level write not clamped");
    a_clamp_high: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && hit_level && wr_level > zsd_pkg::ZSD_LEVEL_MAX
        |=> zero_speed_level_q == zsd_pkg::ZSD_LEVEL_MAX)
        else $error("high level write not clamped");
    a_level_write: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && hit_level && wr_level >= zsd_pkg::ZSD_LEVEL_MIN
        && wr_level <= zsd_pkg::ZSD_LEVEL_MAX
        |=> zero_speed_level_q == $past(wr_level))
        else $error("level write lost");
    a_level_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(reg_wr && hit_level) |=> $stable(zero_speed_level_q))
        else $error("level changed without a write");

    // ------------------------------------------------------------
    // further detector checks
    // ------------------------------------------------------------
    a_set_only_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(zero_speed_flag) |-> $past(below_lo))
        else $error("flag set outside low region");
    a_clear_only_high: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(zero_speed_flag) |-> $past(above_hi))
        else $error("flag cleared outside high region");
    a_pin_needs_flag: assert property (@(posedge clk) disable iff (!rst_n)
        !zero_speed_flag |-> !zsp_pin)
        else $error("pin on without flag");

    // ------------------------------------------------------------
    // main scenarios
    // ------------------------------------------------------------
    c_flag_rise: cover property (@(posedge clk) disable iff (!rst_n) $rose(zero_speed_flag));
    c_flag_fall: cover property (@(posedge clk) disable iff (!rst_n) $fell(zero_speed_flag));
    c_pin_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(zsp_pin));
    c_neg_set: cover property (@(posedge clk) disable iff (!rst_n)
        motor_speed[SPEED_W-1] && below_lo && !zero_speed_flag);
    c_clamp_hit: cover property (@(posedge clk) disable iff (!rst_n)
        reg_wr && hit_level && wr_level > zsd_pkg::ZSD_LEVEL_MAX);
endmodule

/* File: zsd_pkg.sv */
// constants and register map of the zero speed detector
package zsd_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ZSD_LEVEL_OFS = 16'h2434;
    localparam logic [15:0] ZSD_PINSEL_OFS = 16'h2410;
    localparam logic [15:0] ZSD_STATUS_OFS = 16'h2480;
    localparam logic [15:0] ZSD_SPEED_OFS = 16'h2484;
    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [15:0] ZSD_LEVEL_RST = 16'h0032;
    localparam logic [15:0] ZSD_LEVEL_MIN = 16'h000A;
    localparam logic [15:0] ZSD_LEVEL_MAX = 16'h07D0;
    localparam logic [15:0] ZSD_HYST = 16'h000A;
    localparam logic [7:0] ZSD_FUNC_ZSP = 8'h05;
    localparam logic [7:0] ZSD_PINSEL_RST = 8'h00;
endpackage

/* File: zsd_ext_ctrl.sv */
// external controller that counts switch-on events of the zero speed output pin
`timescale 1ns/10ps
module zsd_ext_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched pin and event count
    input wire logic pin,
    output logic [7:0] on_count
);
    logic pin_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 1'b0;
            on_count <= 8'h00;
        end else begin
            pin_q <= pin;
            if (pin && !pin_q) on_count <= on_count + 8'h01;
        end
    end
endmodule

/* File: tb.sv */
// self-checking bench for the zero speed detector
`timescale 1ns/10ps
module tb;
    logic clk = 0;
    logic rst_b = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [31:0] reg_rdata;
    logic signed [15:0] motor_speed = 16'sd1000;
    logic zero_speed_flag;
    logic zsp_pin;
    logic [7:0] on_count;
    logic [31:0] rq[$];
    logic [1:0] fq[$];
    logic pend = 0;
    logic ef = 0;
    logic sel = 0;
    int lvl = 50;
    int ons = 0;
    logic pexp = 0;
    int num_errors = 0;
    int comparisons = 0;
    int m;
    int tbl[9] = '{200, 90, 89, 110, 111, -89, -110, -111, 0};
    always #50 clk = ~clk;
    zsd_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_speed(motor_speed),
        .zero_speed_flag(zero_speed_flag), .zsp_pin(zsp_pin));
    zsd_ext_ctrl u_ext (.clk(clk), .rst_b(rst_b), .pin(zsp_pin), .on_count(on_count));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    // read data one cycle after the strobe, flag and pin after each speed step
    always @(posedge clk) begin
        if (pend) chk(reg_rdata, rq.pop_front());
        if (fq.size() > 0) chk({30'h0, zero_speed_flag, zsp_pin}, {30'h0, fq.pop_front()});
        pend = reg_rd;
    end
    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [15:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        @(posedge clk);
    endtask
    task spd(input int v);
        @(posedge clk);
        motor_speed <= v[15:0];
        m = v < 0 ? -v : v;
        if (m < lvl - 10) ef = 1;
        else if (m > lvl + 10) ef = 0;
        if (ef && sel && !pexp) ons++;
        pexp = ef & sel;
        @(posedge clk);
        #1 fq.push_back({ef, ef & sel});
    endtask
    task give_verdict;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        num_errors++;
        give_verdict;
    end
    initial begin
        m = $urandom(7);
        repeat (12) @(posedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        rd(zsd_pkg::ZSD_LEVEL_OFS, 32'h0000_0032);
        rd(zsd_pkg::ZSD_PINSEL_OFS, 32'h0000_0000);
        rd(16'h2400, 32'h0000_0000);
        wr(zsd_pkg::ZSD_LEVEL_OFS, 32'h0000_0005);
        rd(zsd_pkg::ZSD_LEVEL_OFS, 32'h0000_000A);
        wr(zsd_pkg::ZSD_LEVEL_OFS, 32'h0000_0BB8);
        rd(zsd_pkg::ZSD_LEVEL_OFS, 32'h0000_07D0);
        wr(zsd_pkg::ZSD_LEVEL_OFS, 32'h0000_0064);
        lvl = 100;
        spd(0);
        wr(zsd_pkg::ZSD_PINSEL_OFS, {24'h00_0000, zsd_pkg::ZSD_FUNC_ZSP});
        sel = 1;
        if (ef && !pexp) ons++;
        pexp = ef;
        rd(zsd_pkg::ZSD_STATUS_OFS, 32'h0000_0001);
        foreach (tbl[i]) spd(tbl[i]);
        repeat (200) spd(int'($urandom_range(300)) - 150);
        spd(-77);
        rd(zsd_pkg::ZSD_SPEED_OFS, 32'd77);
        rd(zsd_pkg::ZSD_STATUS_OFS, 32'h0000_0001);
        wr(zsd_pkg::ZSD_PINSEL_OFS, 32'h0000_0000);
        sel = 0;
        pexp = 0;
        spd(0);
        repeat (2) @(posedge clk);
        chk({24'h00_0000, on_count}, {24'h00_0000, ons[7:0]});
        give_verdict;
    end
endmodule
